// file: rtl/fmtx_serial_port.v
// write-only two-wire control port of the fm transmitter
`include "fmtx_defs.vh"

module fmtx_serial_port (
	input  wire        clock,            // 100 mhz system clock
	input  wire        nrst,             // async reset, active low
	input  wire        sclPin,           // serial clock from master
	input  wire        sdaPin,           // serial data pin level
	output wire        sdaOut,           // serial data drive value
	output wire        sdaDriveN,        // low while acknowledging
	input  wire        dividerClearN,    // tone divider clear pin
	output wire [10:0] carrierDivider,   // carrier divider bits
	output wire        toneOutputEnable, // tone pin enable
	output wire        twoChannelSelect, // stereo when high
	output wire        guideToneEnable,  // pilot allowed when high
	output wire        sleepSelect,      // standby when high
	output wire        audioSilence,     // mute when high
	output wire [1:0]  sparePair,        // spare bits as written
	output wire [2:0]  carrierLevelCode, // carrier output level
	output wire [2:0]  audioLossCode,    // audio attenuation step
	output wire [6:0]  refDivider,       // reference divider bits
	output wire        counterCheck,     // counter check mode
	output wire        pilotActive,      // pilot in composite out
	output wire        pilotPhase,       // 19 khz pilot phase
	output wire        pilotRateSquare   // 19 khz square pin
);

	// ==========================================================
	// fsm states
	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_RECV = 5'h02;
	localparam [4:0] S_ACK  = 5'h04;
	localparam [4:0] S_SKIP = 5'h08;
	localparam [4:0] S_HOLD = 5'h10;

	localparam [10:0] OSC_LAST = `FMTX_OSC_LAST;

	// ==========================================================
	// reset release
	reg rstMeta_ff;
	reg rstSync_ff;
	wire rstN;

	// the release is synchronised so no flop leaves reset a cycle late
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rstMeta_ff <= 1'b0;
			rstSync_ff <= 1'b0;
		end else begin
			rstMeta_ff <= 1'b1;
			rstSync_ff <= rstMeta_ff;
		end
	end

	assign rstN = rstSync_ff;

	// ==========================================================
	// pin synchronisers
	wire [2:0] pinSync;
	wire       sclNow;
	wire       sdaNow;
	wire       clearNow;

	fmtx_sync #(
		.WIDTH   (3),
		.RST_VAL (1'b1)
	) uPinSync (
		.clock   (clock),
		.rstN    (rstN),
		.asyncIn ({dividerClearN, sdaPin, sclPin}),
		.syncOut (pinSync)
	);

	assign sclNow   = pinSync[0];
	assign sdaNow   = pinSync[1];
	assign clearNow = pinSync[2];

	// ==========================================================
	// link edge and condition detection
	reg  sclPrev_ff;
	reg  sdaPrev_ff;
	wire sclRise;
	wire sclFall;
	wire startCond;
	wire stopCond;

	always @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			sclPrev_ff <= 1'b1;
			sdaPrev_ff <= 1'b1;
		end else begin
			sclPrev_ff <= sclNow;
			sdaPrev_ff <= sdaNow;
		end
	end

	assign sclRise   = sclNow & ~sclPrev_ff;
	assign sclFall   = ~sclNow & sclPrev_ff;
	// data edges while the clock stays high frame a transfer
	assign startCond = sclNow & sclPrev_ff & sdaPrev_ff & ~sdaNow;
	assign stopCond  = sclNow & sclPrev_ff & ~sdaPrev_ff & sdaNow;

	// ==========================================================
	// receive state
	reg [4:0] state_ff;
	reg [4:0] nxt_state;
	reg [7:0] shift_ff;
	reg [7:0] nxt_shift;
	reg [3:0] bitCnt_ff;
	reg [3:0] nxt_bitCnt;
	reg [2:0] byteIdx_ff;
	reg [2:0] nxt_byteIdx;
	reg       ackDrive_ff;
	reg       nxt_ackDrive;
	reg       commit;
	wire      byteDone;
	wire      addrMatch;
	wire      byteAccept;

	assign byteDone  = (bitCnt_ff == `FMTX_BITS_PER_BYTE);
	// reads are refused by leaving the address unacknowledged
	assign addrMatch = (shift_ff[7:1] == `FMTX_SLAVE_ADDR) &&
		(shift_ff[0] == `FMTX_DIR_WRITE);
	assign byteAccept = (byteIdx_ff == 3'h0) ? addrMatch :
		(byteIdx_ff <= `FMTX_LAST_BYTE);

	always @* begin
		nxt_state    = state_ff;
		nxt_shift    = shift_ff;
		nxt_bitCnt   = bitCnt_ff;
		nxt_byteIdx  = byteIdx_ff;
		nxt_ackDrive = ackDrive_ff;
		commit       = 1'b0;
		if (stopCond) begin
			nxt_state    = S_IDLE;
			nxt_ackDrive = 1'b0;
		end else if (startCond) begin
			nxt_state    = S_RECV;
			nxt_bitCnt   = 4'h0;
			nxt_byteIdx  = 3'h0;
			nxt_ackDrive = 1'b0;
		end else begin
			case (state_ff)
				S_IDLE: begin
					nxt_ackDrive = 1'b0;
				end
				S_RECV: begin
					if (sclRise && !byteDone) begin
						nxt_shift  = {shift_ff[6:0], sdaNow};
						nxt_bitCnt = bitCnt_ff + 4'h1;
					end else if (sclFall && byteDone) begin
						if (byteAccept) begin
							nxt_state    = S_ACK;
							nxt_ackDrive = 1'b1;
						end else begin
							nxt_state = S_SKIP;
						end
					end
				end
				S_ACK: begin
					if (sclFall) begin
						nxt_ackDrive = 1'b0;
						commit       = 1'b1;
						nxt_bitCnt   = 4'h0;
						if (byteIdx_ff == `FMTX_LAST_BYTE) begin
							nxt_state = S_HOLD;
						end else begin
							nxt_state   = S_RECV;
							nxt_byteIdx = byteIdx_ff + 3'h1;
						end
					end
				end
				S_SKIP: begin
					nxt_ackDrive = 1'b0;
				end
				S_HOLD: begin
					// extra bytes after the fourth are left unanswered
					nxt_ackDrive = 1'b0;
				end
				default: begin
					nxt_state    = S_IDLE;
					nxt_ackDrive = 1'b0;
				end
			endcase
		end
	end

	always @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			state_ff    <= S_IDLE;
			shift_ff    <= 8'h00;
			bitCnt_ff   <= 4'h0;
			byteIdx_ff  <= 3'h0;
			ackDrive_ff <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			shift_ff    <= nxt_shift;
			bitCnt_ff   <= nxt_bitCnt;
			byteIdx_ff  <= nxt_byteIdx;
			ackDrive_ff <= nxt_ackDrive;
		end
	end

	// open-drain: only ever pulls low, never drives high
	assign sdaOut    = 1'b0;
	assign sdaDriveN = ~ackDrive_ff;

	// ==========================================================
	// control registers
	reg [7:0] byte1_ff;
	reg [7:0] byte2_ff;
	reg [7:0] byte3_ff;
	reg [7:0] byte4_ff;

	// a byte lands only once its acknowledge clock has ended
	always @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			byte1_ff <= `FMTX_BYTE1_RST;
			byte2_ff <= `FMTX_BYTE2_RST;
			byte3_ff <= `FMTX_BYTE3_RST;
			byte4_ff <= `FMTX_BYTE4_RST;
		end else if (commit) begin
			case (byteIdx_ff)
				3'h1: begin
					byte1_ff <= shift_ff;
				end
				3'h2: begin
					byte2_ff <= shift_ff;
				end
				3'h3: begin
					byte3_ff <= shift_ff;
				end
				3'h4: begin
					byte4_ff <= shift_ff;
				end
				default: begin
					byte1_ff <= byte1_ff;
				end
			endcase
		end
	end

	// ==========================================================
	// field outputs
	assign carrierDivider = {byte1_ff,
		byte2_ff[`FMTX_B2_DIV_HI:`FMTX_B2_DIV_LO]};
	assign toneOutputEnable = byte2_ff[`FMTX_B2_TONE];
	assign twoChannelSelect = byte2_ff[`FMTX_B2_STEREO];
	assign guideToneEnable  = byte2_ff[`FMTX_B2_PILOT];
	assign sleepSelect      = byte2_ff[`FMTX_B2_SLEEP];
	assign audioSilence     = byte2_ff[`FMTX_B2_SILENCE];
	// spare bits are stored as written, never interpreted
	assign sparePair = byte3_ff[`FMTX_B3_SPARE_HI:`FMTX_B3_SPARE_LO];
	assign carrierLevelCode =
		byte3_ff[`FMTX_B3_LEVEL_HI:`FMTX_B3_LEVEL_LO];
	assign audioLossCode = byte3_ff[`FMTX_B3_LOSS_HI:`FMTX_B3_LOSS_LO];
	assign refDivider   = byte4_ff[`FMTX_B4_REF_HI:`FMTX_B4_REF_LO];
	assign counterCheck = byte4_ff[`FMTX_B4_CHECK];

	// ==========================================================
	// pilot generation
	reg        pilotActive_ff;
	reg [10:0] oscCnt_ff;
	reg        oscTick_ff;

	// mono, pilot removal or standby all keep the pilot out
	always @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			pilotActive_ff <= 1'b0;
		end else begin
			pilotActive_ff <= twoChannelSelect & guideToneEnable &
				~sleepSelect;
		end
	end

	assign pilotActive = pilotActive_ff;

	// 76 khz tick stands in for the oscillator; it halts in standby
	always @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			oscCnt_ff  <= 11'h000;
			oscTick_ff <= 1'b0;
		end else if (sleepSelect) begin
			oscCnt_ff  <= 11'h000;
			oscTick_ff <= 1'b0;
		end else if (oscCnt_ff == OSC_LAST) begin
			oscCnt_ff  <= 11'h000;
			oscTick_ff <= 1'b1;
		end else begin
			oscCnt_ff  <= oscCnt_ff + 11'h001;
			oscTick_ff <= 1'b0;
		end
	end

	fmtx_tone_div uToneDiv (
		.clock   (clock),
		.rstN    (rstN),
		.oscTick (oscTick_ff),
		.clearN  (clearNow),
		.enable  (toneOutputEnable),
		.square  (pilotRateSquare),
		.phase   (pilotPhase)
	);

endmodule

// file: pkg/fmtx_defs.vh
// constants for the fm transmitter serial control port
`ifndef FMTX_DEFS_VH
`define FMTX_DEFS_VH

// ==========================================================
// link addressing
`define FMTX_SLAVE_ADDR      7'h68
`define FMTX_DIR_WRITE       1'b0
`define FMTX_LAST_BYTE       3'h4
`define FMTX_BITS_PER_BYTE   4'h8

// ==========================================================
// control byte reset values
`define FMTX_BYTE1_RST       8'h7A
`define FMTX_BYTE2_RST       8'h8C
`define FMTX_BYTE3_RST       8'h3B
`define FMTX_BYTE4_RST       8'hA0

// ==========================================================
// control byte 2 field positions
`define FMTX_B2_DIV_HI       7
`define FMTX_B2_DIV_LO       5
`define FMTX_B2_TONE         4
`define FMTX_B2_STEREO       3
`define FMTX_B2_PILOT        2
`define FMTX_B2_SLEEP        1
`define FMTX_B2_SILENCE      0

// ==========================================================
// control byte 3 and 4 field positions
`define FMTX_B3_SPARE_HI     7
`define FMTX_B3_SPARE_LO     6
`define FMTX_B3_LEVEL_HI     5
`define FMTX_B3_LEVEL_LO     3
`define FMTX_B3_LOSS_HI      2
`define FMTX_B3_LOSS_LO      0
`define FMTX_B4_REF_HI       7
`define FMTX_B4_REF_LO       1
`define FMTX_B4_CHECK        0

// ==========================================================
// timing
`define FMTX_CLK_HZ          100000000
`define FMTX_OSC_HZ          76000
`define FMTX_OSC_CYCLES      (`FMTX_CLK_HZ / `FMTX_OSC_HZ)
// last count of the tick divider, 1315 clocks per 76 khz tick
`define FMTX_OSC_LAST        11'h522
`define FMTX_TONE_RATIO      4

`endif

// file: rtl/fmtx_sync.v
// two flip-flop synchroniser for pins from outside the clock domain
module fmtx_sync #(
	parameter       WIDTH   = 1,
	parameter       RST_VAL = 1'b1
) (
	input  wire             clock,   // system clock
	input  wire             rstN,    // async reset, active low
	input  wire [WIDTH-1:0] asyncIn, // raw pin levels
	output wire [WIDTH-1:0] syncOut  // levels in clock domain
);

	reg [WIDTH-1:0] stage1_ff;
	reg [WIDTH-1:0] stage2_ff;

	// first stage feeds only the second stage
	always @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			stage1_ff <= {WIDTH{RST_VAL}};
			stage2_ff <= {WIDTH{RST_VAL}};
		end else begin
			stage1_ff <= asyncIn;
			stage2_ff <= stage1_ff;
		end
	end

	assign syncOut = stage2_ff;

endmodule

// file: rtl/fmtx_tone_div.v
// divide-by-four from the 76 khz tick to the 19 khz square wave
`include "fmtx_defs.vh"

module fmtx_tone_div (
	input  wire clock,    // system clock
	input  wire rstN,     // async reset, active low
	input  wire oscTick,  // one-cycle pulse at 76 khz
	input  wire clearN,   // synchronised divider clear, active low
	input  wire enable,   // tone output enable
	output wire square,   // 19 khz square, low when disabled
	output wire phase     // internal 19 khz phase, shared with pilot
);

	reg [1:0] count_ff;
	reg       square_ff;

	// ==========================================================
	// divider with its own clear
	always @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			count_ff <= 2'h0;
		end else if (!clearN) begin
			count_ff <= 2'h0;
		end else if (oscTick) begin
			count_ff <= count_ff + 2'h1;
		end
	end

	// ==========================================================
	// gated output register
	always @(posedge clock or negedge rstN) begin
		if (!rstN) begin
			square_ff <= 1'b0;
		end else begin
			square_ff <= enable & count_ff[1];
		end
	end

	assign square = square_ff;
	assign phase  = count_ff[1];

endmodule

// file: test/fmtx_port_props.sv
// assertions on the pins of the fm transmitter control port
module fmtx_port_props (
	input wire        clock,            // system clock
	input wire        nrst,             // reset, active low
	input wire        sclPin,           // serial clock
	input wire        sdaDriveN,        // ack drive, active low
	input wire        dividerClearN,    // divider clear, active low
	input wire [10:0] carrierDivider,   // control field
	input wire        toneOutputEnable, // control field
	input wire        twoChannelSelect, // control field
	input wire        guideToneEnable,  // control field
	input wire        sleepSelect,      // control field
	input wire        audioSilence,     // control field
	input wire [1:0]  sparePair,        // control field
	input wire [2:0]  carrierLevelCode, // control field
	input wire [2:0]  audioLossCode,    // control field
	input wire [6:0]  refDivider,       // control field
	input wire        counterCheck,     // control field
	input wire        pilotActive,      // pilot in composite
	input wire        pilotPhase,       // 19 khz phase
	input wire        pilotRateSquare   // 19 khz pin
);
	timeunit 1ns;
	timeprecision 1ps;

	wire [31:0] fields = {carrierDivider, toneOutputEnable,
		twoChannelSelect, guideToneEnable, sleepSelect, audioSilence,
		sparePair, carrierLevelCode, audioLossCode, refDivider, counterCheck};

	// ====================================================
	// properties
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	ack_hold_a: assert property (
		$fell(sdaDriveN) |-> !sdaDriveN [*6])
		else $error("ack released too early");
	// the ack may only move while scl is low, or it reads as start/stop
	ack_edge_a: assert property ($changed(sdaDriveN) |-> !sclPin)
		else $error("ack moved while scl high");
	commit_sync_a: assert property (
		$changed(fields) |-> $rose(sdaDriveN))
		else $error("field changed outside ack end");
	tone_off_a: assert property (
		!toneOutputEnable |=> !pilotRateSquare)
		else $error("tone pin high while disabled");
	square_phase_a: assert property ($past(nrst) |->
		pilotRateSquare == $past(toneOutputEnable && pilotPhase))
		else $error("tone pin out of phase");
	pilot_rel_a: assert property ($past(nrst, 3) |-> pilotActive ==
		$past(twoChannelSelect && guideToneEnable && !sleepSelect))
		else $error("pilot state wrong");
	sleep_pilot_a: assert property (sleepSelect |=> !pilotActive)
		else $error("pilot on in standby");
	clear_hold_a: assert property (!dividerClearN [*6] |->
		!pilotPhase && !pilotRateSquare)
		else $error("divider runs while cleared");
endmodule

bind fmtx_serial_port fmtx_port_props u_props (
	.clock, .nrst, .sclPin, .sdaDriveN, .dividerClearN, .carrierDivider,
	.toneOutputEnable, .twoChannelSelect, .guideToneEnable, .sleepSelect,
	.audioSilence, .sparePair, .carrierLevelCode, .audioLossCode,
	.refDivider, .counterCheck, .pilotActive, .pilotPhase, .pilotRateSquare
);

// file: test/fmtx_host_model.sv
// two-wire bus master that writes the control port
module fmtx_host_model (
	output logic sclPin,     // serial clock, idles high
	output logic hostSdaEnN, // pulls data low when low
	input  wire  sdaPin      // resolved data wire
);
	timeunit 1ns;
	timeprecision 1ps;

	// no reference clock is driven from here

	initial begin
		sclPin = 1'b1;
		hostSdaEnN = 1'b1;
	end

	// scl low 60 ns, high 20 ns: the long low phase leaves the slave
	// room to release its ack before the next bit is sampled
	task automatic put_bit(input logic v, output logic seen);
		#20 hostSdaEnN = v;
		#40 sclPin = 1'b1;
		#10 seen = sdaPin;
		#10 sclPin = 1'b0;
	endtask

	task automatic put_byte(input logic [7:0] d, output logic nak);
		for (int i = 7; i >= 0; i--)
			put_bit(d[i], nak);
		put_bit(1'b1, nak);
	endtask

	task automatic start_cond();
		#3 hostSdaEnN = 1'b0;
		#40 sclPin = 1'b0;
	endtask

	task automatic stop_cond();
		#20 hostSdaEnN = 1'b0;
		#40 sclPin = 1'b1;
		#30 hostSdaEnN = 1'b1;
		#50;
	endtask
endmodule

// file: test/test_fmtx_serial_port.sv
// self-checking bench for the fm transmitter control port
module test_fmtx_serial_port;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 1315;
	localparam logic [31:0] DEFS = 32'h7A8C3BA0;
	logic        clock, nrst, dividerClearN;
	wire         sclPin, hostSdaEnN, sdaPin, sdaOut, sdaDriveN;
	wire         toneOutputEnable, twoChannelSelect, guideToneEnable;
	wire         sleepSelect, audioSilence, counterCheck;
	wire         pilotActive, pilotPhase, pilotRateSquare;
	wire  [10:0] carrierDivider;
	wire  [6:0]  refDivider;
	wire  [2:0]  carrierLevelCode, audioLossCode;
	wire  [1:0]  sparePair;
	wire  [31:0] flds;
	int          failures = 0, num_checks = 0, n;
	logic [5:0]  nak;
	logic [7:0]  b;
	logic        ak;
	logic [7:0]  tbl [4] = '{8'h7C, 8'h78, 8'h7E, 8'h64};
	logic [7:0]  bad [2] = '{8'hD1, 8'hA0};

	// data line has a pull-up: high unless someone pulls it low
	assign sdaPin = hostSdaEnN & (sdaDriveN | sdaOut);
	assign flds = {carrierDivider, toneOutputEnable, twoChannelSelect,
		guideToneEnable, sleepSelect, audioSilence, sparePair,
		carrierLevelCode, audioLossCode, refDivider, counterCheck};

	fmtx_serial_port u_dut (
		.clock, .nrst, .sclPin, .sdaPin, .sdaOut, .sdaDriveN, .dividerClearN,
		.carrierDivider, .toneOutputEnable, .twoChannelSelect,
		.guideToneEnable, .sleepSelect, .audioSilence, .sparePair,
		.carrierLevelCode, .audioLossCode, .refDivider, .counterCheck,
		.pilotActive, .pilotPhase, .pilotRateSquare
	);
	fmtx_host_model u_host (.sclPin, .hostSdaEnN, .sdaPin);

	initial clock = 1'b0;
	always #5 clock = ~clock;

	// ====================================================
	// tasks
	task automatic chk(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic frame(input logic [47:0] d, input int cnt,
		output logic [5:0] nk);
		logic a;
		nk = '0;
		u_host.start_cond();
		for (int i = 0; i < cnt; i++) begin
			u_host.put_byte(d[47 - 8 * i -: 8], a);
			nk = {nk[4:0], a};
		end
		u_host.stop_cond();
		repeat (4) @(posedge clock);
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#500us;
		failures++;
		end_sim();
	end

	// ====================================================
	// tests
	initial begin
		nrst = 1'b0;
		dividerClearN = 1'b1;
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		repeat (8) @(posedge clock);
		chk("defaults", DEFS, flds);
		chk("pilot", 1, pilotActive);
		$display("test defaults done");
		frame({8'hD0, 32'hA5752E2B, 8'h5A}, 6, nak);
		chk("acks", 6'h01, nak);
		chk("fields", 32'hA5752E2B, flds);
		chk("mono", 0, pilotActive);
		$display("test write done");
		@(posedge pilotRateSquare);
		n = 0;
		while (pilotRateSquare === 1'b1 && n < 3 * TICK) begin
			@(negedge clock);
			n++;
		end
		chk("square high", 2 * TICK, n - 1);
		@(posedge pilotRateSquare);
		repeat (100) @(posedge clock);
		dividerClearN <= 1'b0;
		repeat (10) @(posedge clock);
		chk("clear", 0, {pilotPhase, pilotRateSquare});
		dividerClearN <= 1'b1;
		$display("test tone done");
		foreach (tbl[i]) begin
			frame({8'hD0, 8'hA5, tbl[i], 24'h0}, 3, nak);
			b = {7'h00, tbl[i][3] & tbl[i][2] & ~tbl[i][1]};
			chk("pilot", b, pilotActive);
			chk("byte 2", tbl[i], flds[23:16]);
		end
		$display("test pilot done");
		for (int i = 0; i < 8; i++) begin
			b = {2'b00, i[2:0], ~i[2:0]};
			frame({8'hD0, 8'hA5, 8'h64, b, 16'h0}, 4, nak);
			chk("level loss", b, flds[15:8]);
		end
		$display("test codes done");
		foreach (bad[i]) begin
			frame({bad[i], 40'h0}, 3, nak);
			chk("refused", 6'h07, nak);
			chk("kept", 8'h64, flds[23:16]);
		end
		frame({8'hD0, 8'h3C, 32'hFFFFFFFF}, 2, nak);
		chk("partial", {8'h3C, 8'h64}, flds[31:16]);
		// a stop in mid-byte must leave the register untouched
		u_host.start_cond();
		u_host.put_byte(8'hD0, ak);
		chk("cut ack", 1'b0, ak);
		repeat (4) u_host.put_bit(1'b1, ak);
		u_host.stop_cond();
		repeat (4) @(posedge clock);
		chk("cut byte", 8'h3C, flds[31:24]);
		$display("test refusal done");
		nrst <= 1'b0;
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		repeat (8) @(posedge clock);
		chk("reset again", DEFS, flds);
		$display("test reset done");
		end_sim();
	end
endmodule
